// file: link_station_cfg.svh
// link_station_cfg.svh: register offsets, field positions, reset values and
// switch decode constants for the fieldbus station configuration block.
// assumes nothing but being included by bare name; definitions only.
`ifndef LINK_STATION_CFG_SVH
`define LINK_STATION_CFG_SVH

// register byte offsets on the axi4-lite slave
`define CFG_OFS_STATUS       8'h00
`define CFG_OFS_CTRL         8'h04
`define CFG_OFS_LIVE         8'h08

// status register field positions
`define CFG_STAT_RATE_BIT    5
`define CFG_STAT_FRAME_BIT   1
`define CFG_STAT_ADDROK_BIT  2
`define CFG_STAT_RESV_BIT    3
`define CFG_STAT_LATCH_BIT   4
`define CFG_STAT_ONLINE_BIT  0
`define CFG_STAT_ADDR_LSB    8
`define CFG_STAT_BYTES_LSB   16
`define CFG_STAT_DIP_LSB     24
`define CFG_STAT_ROT_LSB     28

// control register: bit 0 holds the station off the link
`define CFG_CTRL_MUTE_BIT    0
`define CFG_CTRL_RST         1'h0

// live register: raw switches and the pending-change flag
`define CFG_LIVE_DIP_LSB     0
`define CFG_LIVE_ROT_LSB     4
`define CFG_LIVE_PEND_BIT    8

// link dip switch pin positions (pin 1 is bit 0)
`define CFG_DIP_RATE         0
`define CFG_DIP_FRAME        1
`define CFG_DIP_BASE         2
`define CFG_DIP_RESV         3

// station address bases and frame byte counts
`define CFG_ADDR_BASE_LO     8'h40
`define CFG_ADDR_BASE_HI     8'h50
`define CFG_ADDR_FACTORY     8'h41
`define CFG_FRAME_SHORT      6'h11
`define CFG_FRAME_LONG       6'h20

// axi response codes
`define CFG_RESP_OKAY        2'h0
`define CFG_RESP_SLVERR      2'h2

`endif

// file: link_station_pkg.sv
// link_station_pkg.sv: types shared by the station configuration block.
// assumes the constants header is compiled alongside.
`default_nettype none
package link_station_pkg;

    // one-hot sequencer: sample once after reset, then hold forever
    typedef enum logic [1:0] {
        ST_SAMPLE = 2'h1,
        ST_HOLD   = 2'h2
    } cfg_state_t;

    // entire state of the top module
    typedef struct packed {
        cfg_state_t  state;
        logic        latched;
        logic [3:0]  dip;
        logic [3:0]  rot;
        logic        rate_10m;
        logic        frame_32b;
        logic [5:0]  frame_bytes;
        logic [7:0]  addr;
        logic        addr_ok;
        logic        resv_set;
        logic        online;
        logic        mute;
        logic        aw_got;
        logic [7:0]  aw_addr;
        logic        w_got;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } cfg_regs_t;

endpackage : link_station_pkg
`default_nettype wire

// file: switch_setting_decode.sv
// switch_setting_decode.sv: combinational decode of the link dip switch and
// the address rotary switch into rate, frame length and station address.
// assumes the caller registers the results; no state is kept here.
`timescale 1ns/100ps
`default_nettype none
`include "link_station_cfg.svh"

module switch_setting_decode (
    input  wire logic [3:0] i_dip,
    input  wire logic [3:0] i_rot,
    output logic            o_rate_10m,
    output logic            o_frame_32b,
    output logic [5:0]      o_frame_bytes,
    output logic [7:0]      o_addr,
    output logic            o_addr_ok,
    output logic            o_resv_set
);

    logic [7:0] base;

    // rate and frame length; the legacy rate forces the short frame
    always_comb begin
        o_rate_10m    = i_dip[`CFG_DIP_RATE];
        o_frame_32b   = i_dip[`CFG_DIP_RATE] & i_dip[`CFG_DIP_FRAME];
        o_frame_bytes = o_frame_32b ? `CFG_FRAME_LONG : `CFG_FRAME_SHORT;
    end

    // address = base + rotary value; low base with rotary 0 disables
    always_comb begin
        base      = i_dip[`CFG_DIP_BASE] ? `CFG_ADDR_BASE_HI : `CFG_ADDR_BASE_LO;
        o_addr    = base + {4'h0, i_rot};
        o_addr_ok = i_dip[`CFG_DIP_BASE] | (i_rot != 4'h0);
        // reserved pin has no function; only reported so misuse is visible
        o_resv_set = i_dip[`CFG_DIP_RESV];
    end

endmodule : switch_setting_decode
`default_nettype wire

// file: link_station_config_decode.sv
// link_station_config_decode.sv: latches the station switch settings once
// after power-on reset and serves them on an axi4-lite register slave.
// assumes i_rst_n is the power-on reset and switch inputs are synchronous.
//
// Overview of operation
// - pin 1 off picks 4 Mbps, on picks 10 Mbps; default on.
// - pin 2 off gives 17 byte frames, on gives 32; default on.
// - address is rotary plus 40H or 50H by pin 3; 40H+0 disables.
// - factory switches (pin 3 off, rotary 1) answer at 41H.
// - at 4 Mbps pin 2 is ignored and the frame is 17 bytes.
// - switch changes take effect only after the next power cycle.
//
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "link_station_cfg.svh"

module link_station_config_decode
    import link_station_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    input  wire logic [3:0]  i_link_dip_switch,
    input  wire logic [3:0]  i_address_rotary_switch,
    output logic             o_rate_10m,
    output logic             o_frame_32b,
    output logic [5:0]       o_frame_bytes,
    output logic [7:0]       o_station_addr,
    output logic             o_station_online,
    output logic             o_cfg_latched,
    input  wire logic [7:0]  i_s_axi_awaddr,
    input  wire logic        i_s_axi_awvalid,
    output logic             o_s_axi_awready,
    input  wire logic [31:0] i_s_axi_wdata,
    input  wire logic [3:0]  i_s_axi_wstrb,
    input  wire logic        i_s_axi_wvalid,
    output logic             o_s_axi_wready,
    output logic [1:0]       o_s_axi_bresp,
    output logic             o_s_axi_bvalid,
    input  wire logic        i_s_axi_bready,
    input  wire logic [7:0]  i_s_axi_araddr,
    input  wire logic        i_s_axi_arvalid,
    output logic             o_s_axi_arready,
    output logic [31:0]      o_s_axi_rdata,
    output logic [1:0]       o_s_axi_rresp,
    output logic             o_s_axi_rvalid,
    input  wire logic        i_s_axi_rready
);

    localparam cfg_regs_t REGS_RST = '{state: ST_SAMPLE, default: '0};

    cfg_regs_t r;
    cfg_regs_t n;

    logic        dec_rate_10m;
    logic        dec_frame_32b;
    logic [5:0]  dec_frame_bytes;
    logic [7:0]  dec_addr;
    logic        dec_addr_ok;
    logic        dec_resv_set;
    logic        aw_hs;
    logic        w_hs;
    logic        ar_hs;
    logic        pending;
    logic [31:0] stat_word;
    logic [31:0] live_word;

    // decoder sees the live switches; its result is kept only when sampling
    switch_setting_decode u_decode (
        .i_dip         (i_link_dip_switch),
        .i_rot         (i_address_rotary_switch),
        .o_rate_10m    (dec_rate_10m),
        .o_frame_32b   (dec_frame_32b),
        .o_frame_bytes (dec_frame_bytes),
        .o_addr        (dec_addr),
        .o_addr_ok     (dec_addr_ok),
        .o_resv_set    (dec_resv_set)
    );

    // readback words; pending flags a switch moved since it was latched
    always_comb begin
        pending   = r.latched & ({i_address_rotary_switch, i_link_dip_switch} != {r.rot, r.dip});
        stat_word = 32'h0;
        stat_word[`CFG_STAT_ONLINE_BIT] = r.online;
        stat_word[`CFG_STAT_FRAME_BIT]  = r.frame_32b;
        stat_word[`CFG_STAT_ADDROK_BIT] = r.addr_ok;
        stat_word[`CFG_STAT_RESV_BIT]   = r.resv_set;
        stat_word[`CFG_STAT_LATCH_BIT]  = r.latched;
        stat_word[`CFG_STAT_RATE_BIT]   = r.rate_10m;
        stat_word[`CFG_STAT_ADDR_LSB +: 8]  = r.addr;
        stat_word[`CFG_STAT_BYTES_LSB +: 6] = r.frame_bytes;
        stat_word[`CFG_STAT_DIP_LSB +: 4]   = r.dip;
        stat_word[`CFG_STAT_ROT_LSB +: 4]   = r.rot;
        live_word = 32'h0;
        live_word[`CFG_LIVE_DIP_LSB +: 4] = i_link_dip_switch;
        live_word[`CFG_LIVE_ROT_LSB +: 4] = i_address_rotary_switch;
        live_word[`CFG_LIVE_PEND_BIT]     = pending;
    end

    // next state: switch sampling, station enable and the bus slave
    always_comb begin
        n     = r;
        aw_hs = i_s_axi_awvalid & r.awready;
        w_hs  = i_s_axi_wvalid & r.wready;
        ar_hs = i_s_axi_arvalid & r.arready;

        // one capture on the first edge after reset release, then frozen
        case (r.state)
            ST_SAMPLE: begin
                n.dip         = i_link_dip_switch;
                n.rot         = i_address_rotary_switch;
                n.rate_10m    = dec_rate_10m;
                n.frame_32b   = dec_frame_32b;
                n.frame_bytes = dec_frame_bytes;
                n.addr        = dec_addr;
                n.addr_ok     = dec_addr_ok;
                n.resv_set    = dec_resv_set;
                n.latched     = 1'b1;
                n.state       = ST_HOLD;
            end
            ST_HOLD: begin
                n.state = ST_HOLD;
            end
            default: begin
                n.state = ST_SAMPLE;
            end
        endcase

        // an invalid address or a software mute keeps the station off
        n.online = r.latched & r.addr_ok & ~r.mute;

        // write channels are taken in either order and paired here
        if (aw_hs) begin
            n.aw_got  = 1'b1;
            n.aw_addr = i_s_axi_awaddr;
        end
        if (w_hs) begin
            n.w_got  = 1'b1;
            n.w_data = i_s_axi_wdata;
            n.w_strb = i_s_axi_wstrb;
        end
        if (r.bvalid & i_s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (n.aw_got & n.w_got & ~r.bvalid) begin
            n.aw_got = 1'b0;
            n.w_got  = 1'b0;
            n.bvalid = 1'b1;
            n.bresp  = `CFG_RESP_OKAY;
            case ({n.aw_addr[7:2], 2'h0})
                `CFG_OFS_CTRL: begin
                    if (n.w_strb[0]) begin
                        n.mute = n.w_data[`CFG_CTRL_MUTE_BIT];
                    end
                end
                // read-only words swallow writes without error
                `CFG_OFS_STATUS, `CFG_OFS_LIVE: begin
                    n.bresp = `CFG_RESP_OKAY;
                end
                default: begin
                    n.bresp = `CFG_RESP_SLVERR;
                end
            endcase
        end
        // one write at a time: channels reopen once the response is taken
        n.awready = ~n.aw_got & ~n.bvalid;
        n.wready  = ~n.w_got & ~n.bvalid;

        // read: answer one cycle after the address is taken
        if (r.rvalid & i_s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (ar_hs) begin
            n.rvalid = 1'b1;
            n.rresp  = `CFG_RESP_OKAY;
            case ({i_s_axi_araddr[7:2], 2'h0})
                `CFG_OFS_STATUS: n.rdata = stat_word;
                `CFG_OFS_CTRL:   n.rdata = {31'h0, r.mute};
                `CFG_OFS_LIVE:   n.rdata = live_word;
                default: begin
                    n.rdata = 32'h0;
                    n.rresp = `CFG_RESP_SLVERR;
                end
            endcase
        end
        n.arready = ~n.rvalid;
    end

    // the only register process; reset loads constants only
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r <= REGS_RST;
        end else begin
            r <= n;
        end
    end

    // every output straight from the state register
    assign o_rate_10m       = r.rate_10m;
    assign o_frame_32b      = r.frame_32b;
    assign o_frame_bytes    = r.frame_bytes;
    assign o_station_addr   = r.addr;
    assign o_station_online = r.online;
    assign o_cfg_latched    = r.latched;
    assign o_s_axi_awready  = r.awready;
    assign o_s_axi_wready   = r.wready;
    assign o_s_axi_bresp    = r.bresp;
    assign o_s_axi_bvalid   = r.bvalid;
    assign o_s_axi_arready  = r.arready;
    assign o_s_axi_rdata    = r.rdata;
    assign o_s_axi_rresp    = r.rresp;
    assign o_s_axi_rvalid   = r.rvalid;

    // rate follows pin 1 as it was at the capture
    rate_select_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        $rose(r.latched) |-> o_rate_10m == $past(i_link_dip_switch[`CFG_DIP_RATE]))
        else $error("rate does not follow pin 1 at capture");

    // long frame only with pin 2 on at the fast rate
    frame_length_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        $rose(r.latched) |-> o_frame_bytes ==
            (($past(i_link_dip_switch[1:0]) == 2'h3) ? `CFG_FRAME_LONG : `CFG_FRAME_SHORT))
        else $error("frame length does not follow pins 1 and 2");

    // address is base plus rotary, and 40H+0 never goes online
    addr_form_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        r.latched |-> (o_station_addr == ((r.dip[2] ? `CFG_ADDR_BASE_HI : `CFG_ADDR_BASE_LO)
            + {4'h0, r.rot})) && !(o_station_online && !r.dip[2] && r.rot == 4'h0))
        else $error("station address wrongly formed");

    // factory switches answer at the factory address
    factory_addr_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (r.latched && !r.dip[2] && r.rot == 4'h1 && !r.mute) |->
            o_station_addr == `CFG_ADDR_FACTORY ##1 o_station_online)
        else $error("factory setting does not give 41H");

    // legacy rate forces the short frame whatever pin 2 says
    legacy_frame_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (r.latched && !o_rate_10m) |-> !o_frame_32b && o_frame_bytes == `CFG_FRAME_SHORT)
        else $error("legacy rate with long frame");

    // once held, the configuration never moves while powered
    config_hold_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        $past(r.latched) |-> $stable({o_rate_10m, o_frame_bytes, o_station_addr, r.dip, r.rot}))
        else $error("active configuration changed while powered");

    // capture happens on the first edge after reset release; the sampled reset
    // keeps the release edge itself, where nothing is captured yet, out of it
    sample_once_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        i_rst_n && !r.latched |=> r.latched && r.dip == $past(i_link_dip_switch)
            && r.rot == $past(i_address_rotary_switch))
        else $error("switches not sampled at reset release");

endmodule : link_station_config_decode
`default_nettype wire

// file: fieldbus_master_model.sv
// fieldbus_master_model.sv: network master on the far side of the station;
// it reports whether it could poll the station as the station is configured.
// assumes the station outputs are steady once the configuration is latched.
`timescale 1ns/100ps
`default_nettype none

module fieldbus_master_model #(
    parameter logic       LEGACY = 1'b0,
    parameter logic [7:0] ADDR   = 8'h41
) (
    input  wire logic       i_rate_10m,
    input  wire logic [5:0] i_frame_bytes,
    input  wire logic [7:0] i_station_addr,
    input  wire logic       i_station_online,
    output logic            o_link_up
);
    logic rate_ok;
    logic len_ok;

    // a legacy master only runs the slow rate with short frames
    assign rate_ok = LEGACY ? !i_rate_10m : i_rate_10m;
    assign len_ok  = i_frame_bytes == (LEGACY ? 6'h11 : 6'h20);
    // a disabled or foreign station is never polled
    assign o_link_up = rate_ok && len_ok && i_station_online
                       && (i_station_addr == ADDR);
endmodule : fieldbus_master_model
`default_nettype wire

// file: link_station_config_decode_bench.sv
// link_station_config_decode_bench.sv: self-checking bench for the station
// configuration block; drives the switches and an axi4-lite master.
// assumes the package, the constants header and the master model compile first.
`timescale 1ns/100ps
`default_nettype none
`include "link_station_cfg.svh"

module link_station_config_decode_bench import link_station_pkg::*;;
    typedef struct packed {
        logic [3:0] dip;
        logic [3:0] rot;
        logic       rate;
        logic [5:0] bytes;
        logic [7:0] addr;
        logic       online;
    } row_t;

    logic        core_clk, rst_n, rate, f32, online, latched, link_up, legacy_up;
    logic [3:0]  dip, rot, wstrb;
    logic [5:0]  fb;
    logic [7:0]  addr, awaddr, araddr;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, d;
    logic [1:0]  bresp, rresp, r;
    int          miscompares, checks_done;
    row_t        rows [7];

    link_station_config_decode u_link_station_config_decode (
        .i_core_clk(core_clk), .i_rst_n(rst_n), .i_link_dip_switch(dip),
        .i_address_rotary_switch(rot), .o_rate_10m(rate), .o_frame_32b(f32),
        .o_frame_bytes(fb), .o_station_addr(addr), .o_station_online(online),
        .o_cfg_latched(latched), .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
        .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb),
        .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
        .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .i_s_axi_araddr(araddr),
        .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
        .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready));

    fieldbus_master_model u_fieldbus_master_model (
        .i_rate_10m(rate), .i_frame_bytes(fb), .i_station_addr(addr),
        .i_station_online(online), .o_link_up(link_up));

    // a legacy master polling 45H, the address of legacy-capable row 2; row 5 also runs slow with short frames but sits at 5FH
    fieldbus_master_model #(.LEGACY(1'b1), .ADDR(8'h45)) u_legacy_master (
        .i_rate_10m(rate), .i_frame_bytes(fb), .i_station_addr(addr),
        .i_station_online(online), .o_link_up(legacy_up));

    // free-running core clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic conclude;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude

    // switches are set while reset is low, as a power cycle would
    task automatic power_cycle(input logic [3:0] dv, input logic [3:0] rv);
        @(posedge core_clk);
        rst_n <= 1'b0;
        dip   <= dv;
        rot   <= rv;
        repeat (8) @(posedge core_clk);
        check(32'({latched, online, awready, wready, arready}), 32'h0, "reset");
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
    endtask : power_cycle

    // both channels offered at once, each dropped when taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] rs);
        @(posedge core_clk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= dv;
        wstrb   <= 4'hF;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bready && bvalid));
        rs = bresp;
        bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rs);
        @(posedge core_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rready && rvalid));
        dv = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask : axi_read

    // hang guard: the whole run needs about 140 cycles of the 2000 allowed
    initial begin
        #20000;
        miscompares++;
        conclude();
    end

    // main sequence: table of switch settings, then the awkward cases
    initial begin
        rst_n = 1'b0; dip = 4'h3; rot = 4'h1; awaddr = 8'h00; awvalid = 1'b0;
        wdata = 32'h0; wstrb = 4'h0; wvalid = 1'b0; bready = 1'b0;
        araddr = 8'h00; arvalid = 1'b0; rready = 1'b0;
        miscompares = 0;
        checks_done = 0;
        rows = '{'{4'h3, 4'h1, 1'b1, 6'h20, 8'h41, 1'b1},
                 '{4'h0, 4'h0, 1'b0, 6'h11, 8'h40, 1'b0},
                 '{4'h2, 4'h5, 1'b0, 6'h11, 8'h45, 1'b1},
                 '{4'h1, 4'hF, 1'b1, 6'h11, 8'h4F, 1'b1},
                 '{4'h7, 4'h0, 1'b1, 6'h20, 8'h50, 1'b1},
                 '{4'h4, 4'hF, 1'b0, 6'h11, 8'h5F, 1'b1},
                 '{4'h5, 4'h8, 1'b1, 6'h11, 8'h58, 1'b1}};
        foreach (rows[i]) begin
            power_cycle(rows[i].dip, rows[i].rot);
            check(32'(rate), 32'(rows[i].rate), "rate");
            check(32'(fb), 32'(rows[i].bytes), "frame bytes");
            check(32'(f32), 32'(rows[i].bytes == 6'h20), "frame flag");
            check(32'(addr), 32'(rows[i].addr), "address");
            check(32'(online), 32'(rows[i].online), "online");
            check(32'(latched), 32'h1, "latched");
            check(32'(link_up), 32'(i == 0), "master link");
            check(32'(legacy_up), 32'(i == 2), "legacy master link");
        end
        // switches moved while powered must not reach the outputs
        power_cycle(4'h3, 4'h1);
        dip <= 4'h0;
        rot <= 4'h9;
        repeat (4) @(posedge core_clk);
        check(32'({rate, fb, addr}), 32'({1'b1, 6'h20, 8'h41}), "held config");
        check(32'({awready, wready, arready}), 32'h7, "readies open");
        axi_read(`CFG_OFS_LIVE, d, r);
        check(32'(d[8:0]), 32'h190, "live switches");
        axi_read(`CFG_OFS_STATUS, d, r);
        check(d, 32'h1320_4137, "status");
        axi_read(`CFG_OFS_CTRL, d, r);
        check(d, 32'h0, "ctrl reset");
        // muting drops the station; status is read-only
        axi_write(`CFG_OFS_CTRL, 32'h1, r);
        check(32'(r), 32'(`CFG_RESP_OKAY), "ctrl write resp");
        // online is registered from mute, so it falls one edge after the write lands
        @(posedge core_clk);
        check(32'(online), 32'h0, "muted");
        axi_write(`CFG_OFS_STATUS, 32'hFFFF_FFFF, r);
        check(32'(r), 32'(`CFG_RESP_OKAY), "status write resp");
        axi_read(`CFG_OFS_STATUS, d, r);
        check(d, 32'h1320_4136, "status muted");
        axi_read(8'h0C, d, r);
        check(32'(r), 32'(`CFG_RESP_SLVERR), "unmapped read resp");
        check(d, 32'h0, "unmapped read data");
        axi_write(8'h0C, 32'h1, r);
        check(32'(r), 32'(`CFG_RESP_SLVERR), "unmapped write resp");
        // a new power cycle takes the moved switches and clears mute
        power_cycle(dip, rot);
        check(32'({rate, fb, addr, online}), 32'({1'b0, 6'h11, 8'h49, 1'b1}), "new config");
        conclude();
    end
endmodule : link_station_config_decode_bench
`default_nettype wire
